// *** rtl/four_level_adc_map.svh ***
`ifndef FOUR_LEVEL_ADC_MAP_SVH
`define FOUR_LEVEL_ADC_MAP_SVH
// What this block does
// R1: A high bandwidth select picks the 2 kHz filter cutoff and a low one picks the 1 kHz cutoff.
// R2: The two mode-select inputs together choose fast track, slow track, hold or low-power standby.
// R3: First then second mode pin: 00 standby, 01 fast track, 10 hold, 11 slow track, and the decoder drives them so.
// R4: Outside test mode the converter acts on edges of its 38.4 kHz clock, in test mode on its level.
// R5: Every control input is latched on the falling edge of the converter clock; in test mode the code latches them every system cycle while the clock is high.
// R6: A high track gate stops the peak and valley counters, a low one lets them track.
// R7: While the track gate is low the counters keep decaying at the rate of the current tracking mode.
// R8: Fast track steps the peak counter down by 8 and up by 4, slow track up by 2 and down by 1 every 40 clocks.
// R9: The 2-bit result leaves with bit 0 on the low output and bit 1 on the high output.
// R10: In normal use the board holds the test input at ground.
// R11: Two 8-bit levels from the peak and valley counters set the upper and lower thresholds of the conversion.
// R12: The decoder drives the track gate from its hold_off input, setting it once per converter clock pulse.

`define ADDR_CFG 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_PEAK 4'h2
`define ADDR_VALLEY 4'h3

`define CFG_RESET 8'h00
`define CFG_OVR_BIT 0
`define CFG_WIDE_BIT 1
`define CFG_M1_BIT 2
`define CFG_M2_BIT 3
`define CFG_GATE_BIT 4
`define CFG_TEST_BIT 5

`define CTRL_RESET 5'h08
`define LEVEL_RESET 8'h80
`define FAST_UP_STEP 8'h04
`define FAST_DOWN_STEP 8'h08
`define SLOW_UP_STEP 8'h02
`define SLOW_DOWN_STEP 8'h01
`define FAST_DECAY_TICKS 1
`define SLOW_DECAY_TICKS 40
`define THRESH_LOW 8'h32
`define THRESH_MID 8'h80
`define THRESH_HIGH 8'hCE
`endif

// *** rtl/four_level_adc_pkg.sv ***
package four_level_adc_pkg;
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_FAST = 2'b01,
        MODE_SLOW = 2'b11,
        MODE_HOLD = 2'b10
    } mode_t;

    typedef struct packed {
        logic test;
        logic tracking_gate_n;
        logic mode_select_second;
        logic mode_select_first;
        logic filter_bandwidth_select;
    } ctrl_t;
endpackage

// *** rtl/tracking_counter.sv ***
`include "four_level_adc_map.svh"
module tracking_counter
    import four_level_adc_pkg::*;
#(
    parameter int W = 8,
    parameter int PW = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic track_en,
    input wire logic invert,
    input wire logic [W-1:0] sample,
    input wire logic [W-1:0] up_step,
    input wire logic [W-1:0] down_step,
    input wire logic [PW-1:0] period,
    output logic [W-1:0] level
);
    generate
        if (W < 2 || PW < 1) begin : g_bad_width
            $error("W must be at least 2 and PW at least 1");
        end
    endgenerate

    // The valley runs the same loop on inverted values, so one body serves both counters.
    logic [W-1:0] lvl_q, lvl_d, x;
    logic [PW-1:0] tmr_q, tmr_d;

    always_comb begin
        x = invert ? ~sample : sample;
        lvl_d = lvl_q;
        tmr_d = tmr_q;
        if (tick && track_en) begin // [R6]
            if (x > lvl_q) begin
                lvl_d = ((x - lvl_q) > up_step) ? W'(lvl_q + up_step) : x; // [R8]
                tmr_d = PW'(1);
            end else if (tmr_q <= PW'(1)) begin
                lvl_d = ((lvl_q - x) > down_step) ? W'(lvl_q - down_step) : x; // [R7] [R8]
                tmr_d = period;
            end else begin
                tmr_d = PW'(tmr_q - PW'(1)); // [R7]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= `LEVEL_RESET;
            tmr_q <= PW'(1);
        end else begin
            lvl_q <= lvl_d;
            tmr_q <= tmr_d;
        end
    end

    assign level = invert ? ~lvl_q : lvl_q;
endmodule

// *** rtl/four_level_adc_control.sv ***
`include "four_level_adc_map.svh"
module four_level_adc_control
    import four_level_adc_pkg::*;
#(
    parameter int SLOW_DECAY_TICKS = `SLOW_DECAY_TICKS
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CONV_CLK,
    input wire logic FILTER_BANDWIDTH_SELECT,
    input wire logic MODE_SELECT_FIRST,
    input wire logic MODE_SELECT_SECOND,
    input wire logic TRACKING_GATE_N,
    input wire logic TEST_ENABLE,
    input wire logic [7:0] FILTER_SAMPLE,
    output logic SYMBOL_BIT_LOW,
    output logic SYMBOL_BIT_HIGH,
    output logic FILTER_WIDE,
    output logic STANDBY,
    output logic [7:0] PEAK_DAC,
    output logic [7:0] VALLEY_DAC,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    output logic [7:0] REG_RDATA
);
    localparam int PW = 6;

    generate
        if (SLOW_DECAY_TICKS < 1 || SLOW_DECAY_TICKS > 63) begin : g_bad_ticks
            $error("SLOW_DECAY_TICKS must lie between 1 and 63");
        end
    endgenerate

    // Pin synchronisers and the control latch.
    ctrl_t pins, eff, ctrl_q, ctrl_d;
    logic [5:0] sync1_q, sync2_q;
    logic [7:0] samp1_q, samp2_q;
    logic clk_prev_q, clk_s, fall, tick;
    logic [7:0] cfg_q, cfg_d;
    mode_t mode;

    assign pins = '{test: TEST_ENABLE, tracking_gate_n: TRACKING_GATE_N,
                    mode_select_second: MODE_SELECT_SECOND, mode_select_first: MODE_SELECT_FIRST,
                    filter_bandwidth_select: FILTER_BANDWIDTH_SELECT};

    always_comb begin
        clk_s = sync2_q[5];
        fall = clk_prev_q && !clk_s;
        // A latched test level turns the clock into a level: each system cycle while it is high is a step.
        tick = ctrl_q.test ? clk_s : fall; // [R4]
        if (cfg_q[`CFG_OVR_BIT]) begin
            eff = '{test: cfg_q[`CFG_TEST_BIT], tracking_gate_n: cfg_q[`CFG_GATE_BIT],
                    mode_select_second: cfg_q[`CFG_M2_BIT], mode_select_first: cfg_q[`CFG_M1_BIT],
                    filter_bandwidth_select: cfg_q[`CFG_WIDE_BIT]};
        end else begin
            eff = ctrl_t'(sync2_q[4:0]);
        end
        ctrl_d = tick ? eff : ctrl_q; // [R5]
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            samp1_q <= 8'h00;
            samp2_q <= 8'h00;
            clk_prev_q <= 1'b0;
            ctrl_q <= ctrl_t'(`CTRL_RESET);
        end else begin
            sync1_q <= {CONV_CLK, pins};
            sync2_q <= sync1_q;
            samp1_q <= FILTER_SAMPLE;
            samp2_q <= samp1_q;
            clk_prev_q <= clk_s;
            ctrl_q <= ctrl_d;
        end
    end

    assign mode = mode_t'({ctrl_q.mode_select_first, ctrl_q.mode_select_second}); // [R2] [R3]
    assign FILTER_WIDE = ctrl_q.filter_bandwidth_select; // [R1]
    assign STANDBY = (mode == MODE_STANDBY);

    // Tracking loop.
    logic track_en;
    logic [7:0] up_step, down_step;
    logic [PW-1:0] period;

    always_comb begin
        track_en = !ctrl_q.tracking_gate_n && (mode == MODE_FAST || mode == MODE_SLOW); // [R6]
        if (mode == MODE_SLOW) begin
            up_step = `SLOW_UP_STEP; // [R8]
            down_step = `SLOW_DOWN_STEP;
            period = PW'(SLOW_DECAY_TICKS);
        end else begin
            up_step = `FAST_UP_STEP; // [R8]
            down_step = `FAST_DOWN_STEP;
            period = PW'(`FAST_DECAY_TICKS);
        end
    end

    tracking_counter #(.W(8), .PW(PW)) u_peak (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(tick),
        .track_en(track_en),
        .invert(1'b0),
        .sample(samp2_q),
        .up_step(up_step),
        .down_step(down_step),
        .period(period),
        .level(PEAK_DAC)
    );

    tracking_counter #(.W(8), .PW(PW)) u_valley (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(tick),
        .track_en(track_en),
        .invert(1'b1),
        .sample(samp2_q),
        .up_step(up_step),
        .down_step(down_step),
        .period(period),
        .level(VALLEY_DAC)
    );

    // Conversion against thresholds placed between valley and peak.
    logic [7:0] span;
    logic [8:0] thr_low, thr_mid, thr_high;
    logic [15:0] p_low, p_mid, p_high;
    logic [1:0] sym_q, sym_d;

    always_comb begin
        span = (PEAK_DAC > VALLEY_DAC) ? 8'(PEAK_DAC - VALLEY_DAC) : 8'h00;
        p_low = span * `THRESH_LOW;
        p_mid = span * `THRESH_MID;
        p_high = span * `THRESH_HIGH;
        thr_low = {1'b0, VALLEY_DAC} + {1'b0, p_low[15:8]}; // [R11]
        thr_mid = {1'b0, VALLEY_DAC} + {1'b0, p_mid[15:8]};
        thr_high = {1'b0, VALLEY_DAC} + {1'b0, p_high[15:8]};
        // In standby the comparators are down, so the result is parked at zero.
        if (mode == MODE_STANDBY) begin
            sym_d = 2'h0;
        end else if ({1'b0, samp2_q} < thr_low) begin
            sym_d = 2'h0;
        end else if ({1'b0, samp2_q} < thr_mid) begin
            sym_d = 2'h1;
        end else if ({1'b0, samp2_q} < thr_high) begin
            sym_d = 2'h2;
        end else begin
            sym_d = 2'h3;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sym_q <= 2'h0;
        end else begin
            sym_q <= sym_d;
        end
    end

    assign SYMBOL_BIT_LOW = sym_q[0]; // [R9]
    assign SYMBOL_BIT_HIGH = sym_q[1]; // [R9]

    // Register port.
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        cfg_d = cfg_q;
        if (REG_WRITE && REG_ADDR == `ADDR_CFG) begin
            cfg_d = {2'b00, REG_WDATA[5:0]};
        end
        rdata_d = 8'h00;
        if (REG_READ) begin
            if (REG_ADDR == `ADDR_CFG) begin
                rdata_d = cfg_q;
            end else if (REG_ADDR == `ADDR_STATUS) begin
                rdata_d = {1'b0, sym_q, ctrl_q};
            end else if (REG_ADDR == `ADDR_PEAK) begin
                rdata_d = PEAK_DAC;
            end else if (REG_ADDR == `ADDR_VALLEY) begin
                rdata_d = VALLEY_DAC;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_q <= `CFG_RESET;
            rdata_q <= 8'h00;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_fast_attack;
        tick && track_en && mode == MODE_FAST && samp2_q > PEAK_DAC;
    endsequence

    sequence s_slow_decay;
        tick && track_en && mode == MODE_SLOW && samp2_q < PEAK_DAC;
    endsequence

    sequence s_peak_read;
        REG_READ && REG_ADDR == `ADDR_PEAK;
    endsequence

    AST_BW_LATCH: assert property (tick |=> FILTER_WIDE == $past(eff.filter_bandwidth_select)) // [R1] [R5]
        else $error("bandwidth select not taken on the clock step");
    AST_STANDBY_SYMBOL: assert property (STANDBY |=> !SYMBOL_BIT_LOW && !SYMBOL_BIT_HIGH) // [R2] [R3]
        else $error("symbol not parked in standby");
    AST_HOLD_FREEZE: assert property (mode == MODE_HOLD |=> $stable(PEAK_DAC) && $stable(VALLEY_DAC)) // [R2]
        else $error("levels moved in hold");
    AST_GATE_FREEZE: assert property (ctrl_q.tracking_gate_n |=> $stable(PEAK_DAC) && $stable(VALLEY_DAC)) // [R6]
        else $error("levels moved while tracking is gated");
    AST_TEST_LEVEL: assert property (ctrl_q.test && clk_s && !ctrl_q.tracking_gate_n |-> tick) // [R4]
        else $error("test level did not step");
    AST_NO_STEP: assert property (!tick |=> $stable(PEAK_DAC) && $stable(ctrl_q)) // [R5]
        else $error("state changed without a clock step");
    AST_FAST_ATTACK: assert property (s_fast_attack |=> PEAK_DAC > $past(PEAK_DAC) // [R8]
        && 8'(PEAK_DAC - $past(PEAK_DAC)) <= 8'h04)
        else $error("fast attack step wrong");
    AST_SLOW_DECAY: assert property (s_slow_decay |=> PEAK_DAC <= $past(PEAK_DAC) // [R7] [R8]
        && 8'($past(PEAK_DAC) - PEAK_DAC) <= 8'h01)
        else $error("slow decay step wrong");
    AST_LOW_SYMBOL: assert property (!STANDBY && {1'b0, samp2_q} < thr_low |=> sym_q == 2'h0) // [R9] [R11]
        else $error("sample below low threshold gave nonzero symbol");
    AST_PEAK_READ: assert property (s_peak_read |=> REG_RDATA == $past(PEAK_DAC))
        else $error("peak readback wrong");
    AST_IDLE_READ: assert property (!REG_READ |=> REG_RDATA == 8'h00)
        else $error("read data outside the answer cycle");
endmodule

// *** tb/paging_decoder_model.sv ***
module paging_decoder_model
    import four_level_adc_pkg::*;
(
    input wire logic clk,
    input wire logic go,
    input wire mode_t mode,
    input wire logic band_sel,
    input wire logic hold_off,
    output logic conv_clk,
    output ctrl_t pins,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_q;
    initial begin
        conv_clk = 1'b1;
        busy = 1'b0;
        cnt_q = 5'h00;
        pins = '0;
        pins.tracking_gate_n = 1'b1;
    end
    // Controls change mid high phase so they are settled long before the falling edge.
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            cnt_q <= 5'h00;
            pins.filter_bandwidth_select <= band_sel;
            {pins.mode_select_first, pins.mode_select_second} <= mode;
            pins.tracking_gate_n <= hold_off;
            pins.test <= 1'b0;
        end else if (busy) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h07) begin
                conv_clk <= 1'b0;
            end
            if (cnt_q == 5'h0F) begin
                conv_clk <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule

// *** tb/testbench.sv ***
module testbench import four_level_adc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 4;
    logic SYS_CLK = 1'b0, RST_N = 1'b0, go = 1'b0, band_sel = 1'b0, hold_off = 1'b1;
    logic REG_WRITE = 1'b0, REG_READ = 1'b0, conv_clk, busy, sym_lo, sym_hi, wide, stby;
    logic [3:0] REG_ADDR = 4'h0;
    logic [7:0] REG_WDATA = 8'h00, sample = 8'h80, peak_dac, valley_dac, rdata;
    mode_t mode = MODE_STANDBY;
    ctrl_t pins;
    int n_errors = 0, checked = 0, cycles = 0, seed = 32'h414998AE;
    // The valley level q is kept inverted, as the design stores it, so it starts at mid-scale too.
    int pk = 128, q = 128, ptm = 1, vtm = 1, cfg = 0, lmode = 0, lband = 0, lgate = 1;
    mode_t pm [5] = '{MODE_FAST, MODE_FAST, MODE_SLOW, MODE_HOLD, MODE_STANDBY};
    logic pg [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    int pn [5] = '{30, 8, 40, 12, 3};

    paging_decoder_model u_partner (.clk(SYS_CLK), .go(go), .mode(mode), .band_sel(band_sel), .hold_off(hold_off),
        .conv_clk(conv_clk), .pins(pins), .busy(busy));
    four_level_adc_control #(.SLOW_DECAY_TICKS(P)) u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
        .CONV_CLK(conv_clk), .FILTER_BANDWIDTH_SELECT(pins.filter_bandwidth_select),
        .MODE_SELECT_FIRST(pins.mode_select_first), .MODE_SELECT_SECOND(pins.mode_select_second),
        .TRACKING_GATE_N(pins.tracking_gate_n), .TEST_ENABLE(pins.test), .FILTER_SAMPLE(sample),
        .SYMBOL_BIT_LOW(sym_lo), .SYMBOL_BIT_HIGH(sym_hi), .FILTER_WIDE(wide), .STANDBY(stby),
        .PEAK_DAC(peak_dac), .VALLEY_DAC(valley_dac), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(rdata));

    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end

    task automatic summarize();
        if (n_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WRITE <= 1'b1;
        @(posedge SYS_CLK);
        REG_WRITE <= 1'b0;
        if (a == 4'h0) cfg = d & 8'h3F;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_READ <= 1'b1;
        @(posedge SYS_CLK);
        REG_READ <= 1'b0;
        #1 chk("rdata", rdata, exp);
        @(posedge SYS_CLK);
        #1 chk("rdata_idle", rdata, 8'h00);
    endtask

    // Tracking reference: attack by the capped step, decay only when the timer has run down.
    task automatic trk(inout int lv, inout int tm, input int s, input bit fast);
        int up, dn;
        up = fast ? 4 : 2;
        dn = fast ? 8 : 1;
        if (s > lv) begin
            lv += (s - lv < up) ? s - lv : up;
            tm = 1;
        end else if (tm <= 1) begin
            lv -= (lv - s < dn) ? lv - s : dn;
            tm = fast ? 1 : P;
        end else tm--;
    endtask

    task automatic pulse(input mode_t m, input logic g, input logic [7:0] s);
        int t0, t1, t2, v, span, code;
        logic nb;
        nb = 1'($random(seed));
        @(posedge SYS_CLK);
        mode <= m;
        hold_off <= g;
        band_sel <= nb;
        sample <= s;
        go <= 1'b1;
        @(posedge SYS_CLK);
        go <= 1'b0;
        repeat (40) begin
            @(posedge SYS_CLK);
            if (!busy) break;
        end
        #1;
        // The step acts with the controls latched at the previous falling edge.
        if ((lmode == 1 || lmode == 3) && lgate == 0) begin
            trk(pk, ptm, s, lmode == 1);
            trk(q, vtm, 255 - s, lmode == 1);
        end
        lmode = cfg[0] ? {cfg[2], cfg[3]} : m;
        lband = cfg[0] ? cfg[1] : nb;
        lgate = cfg[0] ? cfg[4] : g;
        chk("peak", peak_dac, pk[7:0]);
        chk("valley", valley_dac, 8'(255 - q));
        chk("wide", {7'h00, wide}, lband[7:0]);
        chk("standby", {7'h00, stby}, {7'h00, lmode == 0});
        v = 255 - q;
        span = pk - v;
        t0 = v + span * 50 / 256;
        t1 = v + span * 128 / 256;
        t2 = v + span * 206 / 256;
        code = -1;
        if (lmode == 0) code = 0;
        else if (span > 8 && (s - t0 > 2 || t0 - s > 2) && (s - t1 > 2 || t1 - s > 2)
            && (s - t2 > 2 || t2 - s > 2)) code = (s >= t0) + (s >= t1) + (s >= t2);
        if (code >= 0) chk("symbol", {6'h00, sym_hi, sym_lo}, code[7:0]);
    endtask

    initial begin
        repeat (16) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        @(posedge SYS_CLK);
        #1 chk("peak_rst", peak_dac, 8'h80);
        chk("valley_rst", valley_dac, 8'h7F);
        chk("symbol_rst", {6'h00, sym_hi, sym_lo}, 8'h00);
        // Warm-up at mid-scale lets both levels settle before the random runs.
        repeat (66) pulse(MODE_FAST, 1'b0, 8'h80);
        for (int i = 0; i < 5; i++) begin
            repeat (pn[i]) pulse(pm[i], pg[i], 8'($random(seed)));
        end
        rd(4'h2, pk[7:0]);
        rd(4'h3, 8'(255 - q));
        rd(4'h7, 8'h00);
        wr(4'h7, 8'hFF);
        rd(4'h7, 8'h00);
        wr(4'h0, 8'hC2);
        rd(4'h0, 8'h02);
        wr(4'h0, 8'h07);
        repeat (2) pulse(MODE_STANDBY, 1'b0, 8'($random(seed)));
        wr(4'h0, 8'h00);
        repeat (2) pulse(MODE_STANDBY, 1'b0, 8'($random(seed)));
        rd(4'h1, {7'h00, lband[0]});
        // Test level is taken on a falling edge; after that a config change lands while the clock just stays high.
        wr(4'h0, 8'h23);
        pulse(MODE_STANDBY, 1'b0, 8'h80);
        wr(4'h0, 8'h21);
        repeat (2) @(posedge SYS_CLK);
        #1 chk("wide_test", {7'h00, wide}, 8'h00);
        rd(4'h1, 8'h10);
        summarize();
    end
endmodule
